// File: src/bank_state_tracker.sv
// Four-bank state tracker with command legality checking
`timescale 1ns/1ns

// Operation
// - Tracking only while clock enable held high
// - Idle after precharge period completes
// - Active after activate-to-column delay, no burst
// - Reading until non-auto read burst ends
// - Writing until non-auto write burst ends
// - Activating lasts activate-to-column delay then active
// - Precharging lasts precharge period then idle
// - Read auto precharge returns idle itself
// - Write auto precharge returns idle itself
// - Refresh lasts refresh cycle, then all idle
// - Mode access lasts set delay, then idle
// - Precharge all lasts precharge period
// - Burst stop ends most recent burst if it is non-auto; an auto precharge burst runs on and the stop is flagged
// - Precharge of idle bank is no-operation
// - Idle bank restricts no other bank
// - Busy bank allows commands to others
// - Command encoding on four strobe lines
// - Address bit ten selects auto or all
// - Interrupted auto burst starts its precharge
module bank_state_tracker (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [bank_track_pkg::ADDR_W-1:0] addr,
   output logic [4*3-1:0] bank_states,
   output logic [1:0] dev_state,
   output logic all_idle,
   output logic violation
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int IN_W = 4 + 2 + 1 + bank_track_pkg::ADDR_W;
   logic [IN_W-1:0] sync1_reg;
   logic [IN_W-1:0] sync2_reg;
   logic cke_prev_reg;
   logic [bank_track_pkg::CNT_W-1:0] exit_cnt_reg;

   // Pins cross two flops before any decode reads them
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
      end else begin
         sync1_reg <= {cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low, cke, addr};
         sync2_reg <= sync1_reg;
      end
   end

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   bank_track_pkg::cmd_bus_t cmd;
   wire cke_now = sync2_reg[bank_track_pkg::ADDR_W];
   assign cmd.code = sync2_reg[IN_W-1 -: 4];
   assign cmd.bank = sync2_reg[bank_track_pkg::ADDR_W+2 -: 2];
   assign cmd.addr = sync2_reg[bank_track_pkg::ADDR_W-1:0];

   // Commands count only with clock enable high on both edges and the exit wait over
   wire track_ok = cke_now && cke_prev_reg && (exit_cnt_reg == bank_track_pkg::CNT_ZERO);
   wire selected = track_ok && !cmd.code[bank_track_pkg::CHIP_SELECT_POS];
   wire c_act = selected && (cmd.code == bank_track_pkg::CMD_ACTIVATE);
   wire c_rd = selected && (cmd.code == bank_track_pkg::CMD_READ);
   wire c_wr = selected && (cmd.code == bank_track_pkg::CMD_WRITE);
   wire c_bst = selected && (cmd.code == bank_track_pkg::CMD_BURST_STOP);
   wire c_pre = selected && (cmd.code == bank_track_pkg::CMD_PRECHARGE);
   wire c_ref = selected && (cmd.code == bank_track_pkg::CMD_REFRESH);
   wire c_mrs = selected && (cmd.code == bank_track_pkg::CMD_MODE_LOAD);
   wire ap = cmd.addr[bank_track_pkg::AUTO_PRECHARGE_BIT];
   wire c_burst = c_rd || c_wr;
   wire c_exec = selected && (cmd.code != bank_track_pkg::CMD_NOP);

   // Leaving a low clock enable phase arms the exit wait; cheap stand-in for self refresh exit
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cke_prev_reg <= 1'b0;
         exit_cnt_reg <= bank_track_pkg::CNT_ZERO;
      end else begin
         cke_prev_reg <= cke_now;
         if (cke_now && !cke_prev_reg)
            exit_cnt_reg <= bank_track_pkg::SELF_REFRESH_EXIT_CYC;
         else if (exit_cnt_reg != bank_track_pkg::CNT_ZERO)
            exit_cnt_reg <= exit_cnt_reg - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // Device-wide timer
   // ------------------------------------------------------------
   bank_track_pkg::dev_state_t dev_reg;
   bank_track_pkg::dev_state_t dev_next;
   logic [bank_track_pkg::CNT_W-1:0] dev_cnt_reg;
   logic [bank_track_pkg::CNT_W-1:0] dev_cnt_next;
   wire dev_busy = (dev_reg != bank_track_pkg::DEV_NORMAL);
   wire pre_all = c_pre && ap && !dev_busy;
   logic [3:0] bank_idle;
   logic [3:0] bank_prechargeable;
   logic [3:0] bank_bursting;
   logic [1:0] last_burst_reg;
   logic burst_live_reg;

   // Device-wide state entry and timed exit
   always_comb begin
      dev_next = dev_reg;
      dev_cnt_next = dev_cnt_reg;
      if (dev_busy) begin
         dev_cnt_next = dev_cnt_reg - 8'h01;
         if (dev_cnt_reg == 8'h01)
            dev_next = bank_track_pkg::DEV_NORMAL;
      end else if (c_ref && (&bank_idle)) begin
         dev_next = bank_track_pkg::DEV_REFRESHING;
         dev_cnt_next = bank_track_pkg::REFRESH_CYC;
      end else if (c_mrs && (&bank_idle)) begin
         dev_next = bank_track_pkg::DEV_MODE_ACCESS;
         dev_cnt_next = bank_track_pkg::MODE_SET_CYC;
      end else if (pre_all) begin
         dev_next = bank_track_pkg::DEV_PRECHARGE_ALL;
         dev_cnt_next = bank_track_pkg::PRECHARGE_CYC;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         dev_reg <= bank_track_pkg::DEV_NORMAL;
         dev_cnt_reg <= bank_track_pkg::CNT_ZERO;
      end else begin
         dev_reg <= dev_next;
         dev_cnt_reg <= dev_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // Per-bank state machines
   // ------------------------------------------------------------
   bank_track_pkg::bank_state_t bst_reg [4];
   bank_track_pkg::bank_state_t bst_next [4];
   logic [bank_track_pkg::CNT_W-1:0] bcnt_reg [4];
   logic [bank_track_pkg::CNT_W-1:0] bcnt_next [4];
   logic [3:0] bank_bad;

   // Most recent burst owner, target of burst stop
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         last_burst_reg <= 2'h0;
         burst_live_reg <= 1'b0;
      end else if (c_burst && !dev_busy) begin
         last_burst_reg <= cmd.bank;
         burst_live_reg <= 1'b1;
      end else if (c_bst) begin
         burst_live_reg <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < bank_track_pkg::NUM_BANKS; g++) begin : gen_bank
         wire hit = !dev_busy && (cmd.bank == 2'(g));
         wire other_burst = !dev_busy && c_burst && (cmd.bank != 2'(g));
         wire stop_me = c_bst && burst_live_reg && (last_burst_reg == 2'(g));
         wire cnt_done = (bcnt_reg[g] == 8'h01);
         assign bank_idle[g] = (bst_reg[g] == bank_track_pkg::BANK_IDLE);
         assign bank_prechargeable[g] = (bst_reg[g] == bank_track_pkg::BANK_IDLE) ||
            (bst_reg[g] == bank_track_pkg::BANK_ACTIVE) || (bst_reg[g] == bank_track_pkg::BANK_READING) ||
            (bst_reg[g] == bank_track_pkg::BANK_WRITING);
         assign bank_bursting[g] = (bst_reg[g] == bank_track_pkg::BANK_READING) ||
            (bst_reg[g] == bank_track_pkg::BANK_WRITING);

         always_comb begin
            bst_next[g] = bst_reg[g];
            bcnt_next[g] = (bcnt_reg[g] != bank_track_pkg::CNT_ZERO) ? bcnt_reg[g] - 8'h01 : bcnt_reg[g];
            bank_bad[g] = 1'b0;
            if (pre_all) begin
               bank_bad[g] = !bank_prechargeable[g];
               bst_next[g] = bank_track_pkg::BANK_IDLE;
               bcnt_next[g] = bank_track_pkg::CNT_ZERO;
            end else begin
               unique case (bst_reg[g])
                  bank_track_pkg::BANK_IDLE: begin
                     if (hit && c_act) begin
                        bst_next[g] = bank_track_pkg::BANK_ACTIVATING;
                        bcnt_next[g] = bank_track_pkg::ACTIVATE_CYC;
                     end
                     // Precharge to an idle bank changes nothing
                     bank_bad[g] = hit && (c_rd || c_wr);
                  end
                  bank_track_pkg::BANK_ACTIVATING: begin
                     if (cnt_done)
                        bst_next[g] = bank_track_pkg::BANK_ACTIVE;
                     bank_bad[g] = hit && c_exec && !c_bst;
                  end
                  bank_track_pkg::BANK_ACTIVE, bank_track_pkg::BANK_READING, bank_track_pkg::BANK_WRITING: begin
                     if (bst_reg[g] != bank_track_pkg::BANK_ACTIVE && (cnt_done || stop_me || other_burst))
                        bst_next[g] = bank_track_pkg::BANK_ACTIVE;
                     if (hit && c_burst) begin
                        bst_next[g] = c_rd ? (ap ? bank_track_pkg::BANK_READ_AUTO_PRE : bank_track_pkg::BANK_READING)
                                           : (ap ? bank_track_pkg::BANK_WRITE_AUTO_PRE : bank_track_pkg::BANK_WRITING);
                        bcnt_next[g] = ap ? bank_track_pkg::BURST_CYC + bank_track_pkg::PRECHARGE_CYC
                                          : bank_track_pkg::BURST_CYC;
                     end else if (hit && c_pre) begin
                        bst_next[g] = bank_track_pkg::BANK_PRECHARGING;
                        bcnt_next[g] = bank_track_pkg::PRECHARGE_CYC;
                     end
                     // Burst stop carries no bank of its own, so the burst tracker judges it
                     bank_bad[g] = hit && c_act;
                  end
                  bank_track_pkg::BANK_PRECHARGING: begin
                     if (cnt_done)
                        bst_next[g] = bank_track_pkg::BANK_IDLE;
                     bank_bad[g] = hit && c_exec && !c_bst;
                  end
                  bank_track_pkg::BANK_READ_AUTO_PRE, bank_track_pkg::BANK_WRITE_AUTO_PRE: begin
                     if (cnt_done) begin
                        bst_next[g] = bank_track_pkg::BANK_IDLE;
                     end else if (other_burst && bcnt_reg[g] > bank_track_pkg::PRECHARGE_CYC) begin
                        bcnt_next[g] = bank_track_pkg::PRECHARGE_CYC;
                     end
                     bank_bad[g] = hit && c_exec && !c_bst;
                  end
               endcase
            end
         end

         always_ff @(posedge mclk) begin
            if (!reset_n) begin
               bst_reg[g] <= bank_track_pkg::BANK_IDLE;
               bcnt_reg[g] <= bank_track_pkg::CNT_ZERO;
            end else begin
               bst_reg[g] <= bst_next[g];
               bcnt_reg[g] <= bcnt_next[g];
            end
         end

         // A burst to another bank cuts an auto-precharge burst: only the precharge period remains
         sequence s_cut_tail;
            !bank_idle[g] [*2] ##1 bank_idle[g];
         endsequence

         property p_auto_cut;
            @(posedge mclk) disable iff (!reset_n)
            (!pre_all && other_burst && bcnt_reg[g] > bank_track_pkg::PRECHARGE_CYC &&
             ((bst_reg[g] == bank_track_pkg::BANK_READ_AUTO_PRE) ||
              (bst_reg[g] == bank_track_pkg::BANK_WRITE_AUTO_PRE))) |=> s_cut_tail;
         endproperty
         a_auto_cut: assert property (p_auto_cut) else $error("cut auto precharge burst not shortened");
      end
   endgenerate

   // ------------------------------------------------------------
   // Violation checks
   // ------------------------------------------------------------
   wire dev_bad = dev_busy && c_exec;
   wire need_idle_bad = !dev_busy && (c_ref || c_mrs) && !(&bank_idle);
   // A burst that ran out by itself leaves nothing to stop, whatever the bank lines say
   wire stop_bad = c_bst && !(burst_live_reg && bank_bursting[last_burst_reg]);
   wire violation_next = dev_bad || need_idle_bad || stop_bad || (|bank_bad);

   // Outputs come straight from flops
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         bank_states <= '0;
         dev_state <= 2'h0;
         all_idle <= 1'b1;
         violation <= 1'b0;
      end else begin
         bank_states <= {bst_next[3], bst_next[2], bst_next[1], bst_next[0]};
         dev_state <= dev_next;
         all_idle <= (bst_next[0] == bank_track_pkg::BANK_IDLE) && (bst_next[1] == bank_track_pkg::BANK_IDLE) &&
                     (bst_next[2] == bank_track_pkg::BANK_IDLE) && (bst_next[3] == bank_track_pkg::BANK_IDLE) &&
                     (dev_next == bank_track_pkg::DEV_NORMAL);
         violation <= violation_next;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_refresh_taken;
      !dev_busy && c_ref && (&bank_idle);
   endsequence

   property p_refresh_len;
      @(posedge mclk) disable iff (!reset_n)
      s_refresh_taken |=> (dev_reg == bank_track_pkg::DEV_REFRESHING) [*7] ##1 !dev_busy;
   endproperty
   a_refresh_len: assert property (p_refresh_len) else $error("refresh period wrong");

   property p_mode_len;
      @(posedge mclk) disable iff (!reset_n)
      (!dev_busy && c_mrs && (&bank_idle)) |=> dev_busy ##1 dev_busy ##1 !dev_busy;
   endproperty
   a_mode_len: assert property (p_mode_len) else $error("mode access period wrong");

   property p_pre_all;
      @(posedge mclk) disable iff (!reset_n)
      pre_all |=> (&bank_idle) && (dev_reg == bank_track_pkg::DEV_PRECHARGE_ALL) ##2 !dev_busy;
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all wrong");

   property p_dev_flag;
      @(posedge mclk) disable iff (!reset_n)
      (dev_busy && c_exec) |=> violation;
   endproperty
   a_dev_flag: assert property (p_dev_flag) else $error("busy command not flagged");

   property p_act_len;
      @(posedge mclk) disable iff (!reset_n)
      (!dev_busy && !pre_all && c_act && bank_idle[cmd.bank]) |=>
         (bst_reg[$past(cmd.bank)] == bank_track_pkg::BANK_ACTIVATING) ##2
         (bst_reg[$past(cmd.bank, 3)] == bank_track_pkg::BANK_ACTIVE);
   endproperty
   a_act_len: assert property (p_act_len) else $error("activate delay wrong");

   property p_no_track;
      @(posedge mclk) disable iff (!reset_n)
      (!track_ok && (&bank_idle) && !dev_busy) |=> (&bank_idle) && !dev_busy && !violation;
   endproperty
   a_no_track: assert property (p_no_track) else $error("command taken while tracking is off");

   property p_idle_pre;
      @(posedge mclk) disable iff (!reset_n)
      (!dev_busy && c_pre && !ap && bank_idle[cmd.bank]) |=> bank_idle[$past(cmd.bank)];
   endproperty
   a_idle_pre: assert property (p_idle_pre) else $error("idle precharge changed bank");

   property p_need_idle;
      @(posedge mclk) disable iff (!reset_n)
      (!dev_busy && c_ref && !(&bank_idle)) |=> violation && !dev_busy;
   endproperty
   a_need_idle: assert property (p_need_idle) else $error("refresh with open bank not flagged");

endmodule : bank_state_tracker

// File: src/bank_track_pkg.sv
// Package with command codes, bank states, timing constants and carrier types
package bank_track_pkg;

   // ------------------------------------------------------------
   // Command codes {chip select, row strobe, column strobe, write enable}
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_BURST_STOP = 4'h6;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   localparam logic [3:0] CMD_NOP = 4'h7;

   // ------------------------------------------------------------
   // Geometry and field positions
   // ------------------------------------------------------------
   localparam int NUM_BANKS = 4;
   localparam int ADDR_W = 12;
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam int CHIP_SELECT_POS = 3;

   // ------------------------------------------------------------
   // Timing: times in ns, counts derived at 10 ns clock period
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int PRECHARGE_PERIOD_NS = 20;
   localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
   localparam int REFRESH_CYCLE_NS = 70;
   localparam int MODE_SET_DELAY_NS = 20;
   localparam int SELF_REFRESH_EXIT_TIME_NS = 80;
   localparam int BURST_LEN = 4;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] PRECHARGE_CYC =
      CNT_W'((PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACTIVATE_CYC =
      CNT_W'((ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] REFRESH_CYC =
      CNT_W'((REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MODE_SET_CYC =
      CNT_W'((MODE_SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SELF_REFRESH_EXIT_CYC =
      CNT_W'((SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN);
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READING, BANK_WRITING,
      BANK_PRECHARGING, BANK_READ_AUTO_PRE, BANK_WRITE_AUTO_PRE
   } bank_state_t;

   typedef enum logic [1:0] {
      DEV_NORMAL, DEV_REFRESHING, DEV_MODE_ACCESS, DEV_PRECHARGE_ALL
   } dev_state_t;

   // One sampled command from the controller
   typedef struct packed {
      logic [3:0] code;
      logic [1:0] bank;
      logic [ADDR_W-1:0] addr;
   } cmd_bus_t;

endpackage : bank_track_pkg

// File: bench/cmd_issuer.sv
// Controller-side model that places commands on the strobe, bank and address pins
`timescale 1ns/1ns

// ------------------------------------------------------------
// Command driver
// ------------------------------------------------------------
module cmd_issuer (
   input wire logic mclk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [bank_track_pkg::ADDR_W-1:0] addr
);
   // Bus starts inhibited with clock enable high, as after power-up
   initial begin
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      {bank_select_high, bank_select_low} = 2'h0;
      addr = 12'h000;
   end

   // Clock enable changes on a falling edge so both neighbouring rising edges see one level
   task automatic hold_cke(input logic v);
      @(negedge mclk);
      cke = v;
   endtask : hold_cke

   // One command, set up half a cycle ahead of the rising edge that registers it
   task automatic send(input bank_track_pkg::cmd_bus_t c);
      @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n} = c.code;
      {bank_select_high, bank_select_low} = c.bank;
      addr = c.addr;
   endtask : send

   // Between commands only no-operation; bank and address are meaningless, so show the
   // inverse of the last value rather than a stale copy that could hide a decode slip
   task automatic idle();
      @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n} = bank_track_pkg::CMD_NOP;
      {bank_select_high, bank_select_low} = ~{bank_select_high, bank_select_low};
      addr = ~addr;
   endtask : idle

   // Illegal sequences are sent only when the bench orders them on purpose
endmodule : cmd_issuer

// File: bench/sdram_bank_state_tracker_test.sv
// Self-checking bench for the four-bank state tracker
`timescale 1ns/1ns

module sdram_bank_state_tracker_test;
   logic mclk;
   logic reset_n;
   logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
   logic [11:0] addr;
   logic [11:0] bank_states;
   logic [1:0] dev_state;
   logic all_idle;
   logic violation;
   int err_count = 0;
   int comparisons = 0;
   int viol_seen = 0;
   int v0 = 0;

   // ------------------------------------------------------------
   // Instances, clock and monitors
   // ------------------------------------------------------------
   cmd_issuer cmd_issuer_inst (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr));
   bank_state_tracker bank_state_tracker_inst (.mclk(mclk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_low(bank_select_low),
      .bank_select_high(bank_select_high), .addr(addr), .bank_states(bank_states),
      .dev_state(dev_state), .all_idle(all_idle), .violation(violation));

   // Free-running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Violation is a one-cycle pulse, so it is counted at every edge rather than polled
   always @(posedge mclk) begin
      if (violation === 1'b1) viol_seen++;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Bank b state, or device state when b is 4
   function automatic logic [2:0] view(input int b);
      return (b == 4) ? {1'b0, dev_state} : bank_states[b*3 +: 3];
   endfunction : view

   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (exp !== got) begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic st_is(input int b, input logic [2:0] st);
      check($sformatf("state of unit %0d", b), 12'(st), 12'(view(b)));
   endtask : st_is

   task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      cmd_issuer_inst.send({c, b, a});
   endtask : go

   // One command then idle bus; returns in the first cycle its effect is visible
   task automatic single(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      go(c, b, a);
      cmd_issuer_inst.idle();
      repeat (2) @(negedge mclk);
   endtask : single

   // Bounded count of cycles spent in one state, starting now
   task automatic run_len(input int b, input logic [2:0] st, input logic [7:0] n);
      int k;
      k = 0;
      while (view(b) === st && k < 50) begin
         k++;
         @(negedge mclk);
      end
      check($sformatf("cycles in state %0d", st), {4'h0, n}, 12'(k));
   endtask : run_len

   // Pulses are late by the input synchronisers, so settle before counting
   task automatic viol_delta(input int n);
      repeat (6) @(negedge mclk);
      check("violation pulses", 12'(n), 12'(viol_seen - v0));
   endtask : viol_delta

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Commands during the exit wait or with clock enable low must be ignored
   task automatic sc_startup();
      check("all idle", 12'h001, 12'(all_idle));
      single(bank_track_pkg::CMD_ACTIVATE, 2'h0, 12'h000);
      check("banks", 12'h000, bank_states);
      repeat (12) @(negedge mclk);
      cmd_issuer_inst.hold_cke(1'b0);
      single(bank_track_pkg::CMD_ACTIVATE, 2'h0, 12'h000);
      cmd_issuer_inst.hold_cke(1'b1);
      repeat (14) @(negedge mclk);
      check("banks", 12'h000, bank_states);
   endtask : sc_startup

   task automatic sc_cycle();
      single(bank_track_pkg::CMD_ACTIVATE, 2'h1, 12'h123);
      run_len(1, bank_track_pkg::BANK_ACTIVATING, bank_track_pkg::ACTIVATE_CYC);
      st_is(1, bank_track_pkg::BANK_ACTIVE);
      single(bank_track_pkg::CMD_READ, 2'h1, 12'h010);
      run_len(1, bank_track_pkg::BANK_READING, bank_track_pkg::BURST_CYC);
      st_is(1, bank_track_pkg::BANK_ACTIVE);
      single(bank_track_pkg::CMD_WRITE, 2'h1, 12'h020);
      run_len(1, bank_track_pkg::BANK_WRITING, bank_track_pkg::BURST_CYC);
      single(bank_track_pkg::CMD_PRECHARGE, 2'h1, 12'h000);
      run_len(1, bank_track_pkg::BANK_PRECHARGING, bank_track_pkg::PRECHARGE_CYC);
      st_is(1, bank_track_pkg::BANK_IDLE);
   endtask : sc_cycle

   // Read then write with the auto precharge bit set
   task automatic sc_auto();
      for (int i = 0; i < 2; i++) begin
         single(bank_track_pkg::CMD_ACTIVATE, 2'h2, 12'h0AB);
         repeat (3) @(negedge mclk);
         single(i == 0 ? bank_track_pkg::CMD_READ : bank_track_pkg::CMD_WRITE, 2'h2, 12'h400);
         run_len(2, i == 0 ? bank_track_pkg::BANK_READ_AUTO_PRE : bank_track_pkg::BANK_WRITE_AUTO_PRE,
            bank_track_pkg::BURST_CYC + bank_track_pkg::PRECHARGE_CYC);
         st_is(2, bank_track_pkg::BANK_IDLE);
      end
   endtask : sc_auto

   task automatic sc_device();
      v0 = viol_seen;
      single(bank_track_pkg::CMD_PRECHARGE, 2'h0, 12'h000);
      st_is(0, bank_track_pkg::BANK_IDLE);
      viol_delta(0);
      single(bank_track_pkg::CMD_REFRESH, 2'h0, 12'h000);
      run_len(4, bank_track_pkg::DEV_REFRESHING, bank_track_pkg::REFRESH_CYC);
      check("all idle", 12'h001, 12'(all_idle));
      v0 = viol_seen;
      go(bank_track_pkg::CMD_REFRESH, 2'h0, 12'h000);
      go(bank_track_pkg::CMD_ACTIVATE, 2'h0, 12'h000);
      cmd_issuer_inst.idle();
      viol_delta(1);
      repeat (4) @(negedge mclk);
      st_is(0, bank_track_pkg::BANK_IDLE);
      single(bank_track_pkg::CMD_MODE_LOAD, 2'h0, 12'h030);
      run_len(4, bank_track_pkg::DEV_MODE_ACCESS, bank_track_pkg::MODE_SET_CYC);
      single(bank_track_pkg::CMD_ACTIVATE, 2'h3, 12'h0FF);
      repeat (3) @(negedge mclk);
      v0 = viol_seen;
      single(bank_track_pkg::CMD_REFRESH, 2'h0, 12'h000);
      st_is(4, bank_track_pkg::DEV_NORMAL);
      viol_delta(1);
   endtask : sc_device

   // Bank 3 is still open; open bank 0 too, then close all
   task automatic sc_pre_all();
      single(bank_track_pkg::CMD_ACTIVATE, 2'h0, 12'h001);
      repeat (3) @(negedge mclk);
      v0 = viol_seen;
      single(bank_track_pkg::CMD_PRECHARGE, 2'h1, 12'h400);
      run_len(4, bank_track_pkg::DEV_PRECHARGE_ALL, bank_track_pkg::PRECHARGE_CYC);
      check("banks", 12'h000, bank_states);
      viol_delta(0);
   endtask : sc_pre_all

   // Back-to-back reads on two banks, then burst stop cuts the later one
   task automatic sc_stop();
      go(bank_track_pkg::CMD_ACTIVATE, 2'h0, 12'h002);
      go(bank_track_pkg::CMD_ACTIVATE, 2'h1, 12'h003);
      cmd_issuer_inst.idle();
      repeat (6) @(negedge mclk);
      v0 = viol_seen;
      go(bank_track_pkg::CMD_READ, 2'h0, 12'h400);
      go(bank_track_pkg::CMD_READ, 2'h1, 12'h000);
      go(bank_track_pkg::CMD_BURST_STOP, 2'h0, 12'h000);
      cmd_issuer_inst.idle();
      @(negedge mclk);
      st_is(1, bank_track_pkg::BANK_READING);
      @(negedge mclk);
      st_is(1, bank_track_pkg::BANK_ACTIVE);
      @(negedge mclk);
      st_is(0, bank_track_pkg::BANK_IDLE);
      viol_delta(0);
      v0 = viol_seen;
      single(bank_track_pkg::CMD_BURST_STOP, 2'h1, 12'h000);
      viol_delta(1);
   endtask : sc_stop

   // A read to a bank still activating is refused and flagged
   task automatic sc_busy();
      v0 = viol_seen;
      go(bank_track_pkg::CMD_ACTIVATE, 2'h2, 12'h004);
      go(bank_track_pkg::CMD_READ, 2'h2, 12'h000);
      cmd_issuer_inst.idle();
      viol_delta(1);
      st_is(2, bank_track_pkg::BANK_ACTIVE);
   endtask : sc_busy

   // ------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // Whole run needs well under a thousand cycles
   initial begin
      #50000;
      err_count++;
      close_out();
   end

   initial begin
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      sc_startup();
      sc_cycle();
      sc_auto();
      sc_device();
      sc_pre_all();
      sc_stop();
      sc_busy();
      close_out();
   end
endmodule : sdram_bank_state_tracker_test
